// ===== core/swk_pkg.sv
// shared constants and types for the sleep/wake and external irq 0 block
package swk_pkg;
    // sleep mode field encodings
    localparam logic [2:0] SWK_MODE_IDLE = 3'h0;
    localparam logic [2:0] SWK_MODE_ADC_NR = 3'h1;
    localparam logic [2:0] SWK_MODE_PDOWN = 3'h2;
    localparam logic [2:0] SWK_MODE_PSAVE = 3'h3;
    localparam logic [2:0] SWK_MODE_RSV4 = 3'h4;
    localparam logic [2:0] SWK_MODE_RSV5 = 3'h5;
    localparam logic [2:0] SWK_MODE_STBY = 3'h6;
    localparam logic [2:0] SWK_MODE_XSTBY = 3'h7;
    // sense field encodings
    localparam logic [1:0] SWK_SENSE_LOW = 2'h0;
    localparam logic [1:0] SWK_SENSE_ANY = 2'h1;
    localparam logic [1:0] SWK_SENSE_FALL = 2'h2;
    localparam logic [1:0] SWK_SENSE_RISE = 2'h3;
    // core stall after wake, in cycles
    localparam int SWK_WAKE_STALL = 4;
    localparam logic [2:0] SWK_STALL_LAST = 3'(SWK_WAKE_STALL - 1);
    localparam logic [2:0] SWK_STALL_RST = 3'h0;

    // wake sources from the rest of the chip
    typedef struct packed {
        logic ext_irq;     // any enabled external irq (0/1/2)
        logic ext_level;   // level irq on irq 0 or 1
        logic ext_edge2;   // edge irq on irq 2
        logic int_irq;     // any enabled internal irq
        logic comparator;  // comparator irq
        logic adc_done;    // adc conversion complete irq
        logic twi_match;   // two-wire address match irq
        logic t2_event;    // timer 2 compare or overflow event
        logic t2_async;    // timer 2 clocked asynchronously
    } swk_wake_t;

    // peripheral clock gates, high means running
    typedef struct packed {
        logic cpu;
        logic spi;
        logic usart;
        logic comparator;
        logic adc;
        logic twi;
        logic timers;
        logic timer2;
        logic watchdog;
        logic ext_irq;
    } swk_gate_t;

    typedef enum logic [1:0] {
        SWK_RUN = 2'b00,
        SWK_SLEEP = 2'b01,
        SWK_STALL = 2'b10
    } swk_state_t;
endpackage : swk_pkg

// ===== core/swk_sleep_ctrl.sv
// sleep entry/wake sequencing and external interrupt 0 sense logic
//
// Overview of operation
// RULE1: irq 0 request raised only when global enable and irq 0 mask are set.
// RULE2: pin synchronised first; edges detected on the sampled value only.
// RULE3: edge/toggle pulses longer than one clock always latch a request.
// RULE4: source holds low level until current instruction completes.
// RULE5: sense 00 low, 01 any change, 10 falling, 11 rising edge.
// RULE6: halt sleeps only when sleep_allow is set, else no effect.
// RULE7: three-bit mode field picks which sleep mode halt activates.
// RULE8: enabled irq wakes core, stalls four cycles, then service and resume.
// RULE9: waking never resets register file, sram or i/o contents.
// RULE10: reset while asleep wakes and restarts at the reset vector.
// RULE11: idle stops cpu, keeps serial, analog, timers, watchdog, irqs running.
// RULE12: idle wakes on any enabled internal or external interrupt.
// RULE13: comparator_off powers comparator down; no idle wake from it.
// RULE14: adc enabled on idle or adc noise entry starts a conversion.
// RULE15: adc noise mode keeps adc, ext irqs, twi watch, timer 2, watchdog.
// RULE16: adc noise wakes only on adc, resets, twi match, levels, irq2 edge. Code also wakes on any timer 2 event.
// RULE17: adc noise timer 2 event wakes, no irq unless timer 2 async.
// RULE18: mode 000 idle, 001 adc noise, 010/011/110/111 others, 100/101 reserved.
// RULE19: sleep_allow is never cleared by hardware on wake.
`timescale 1ns/1ps
module swk_sleep_ctrl
    import swk_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control bits from software
    input wire logic sleep_allow,
    input wire logic [2:0] sleep_sel_field,
    input wire logic irq_zero_sense_hi,
    input wire logic irq_zero_sense_lo,
    input wire logic global_irq_en,
    input wire logic irq_zero_mask,
    input wire logic comparator_off,
    input wire logic adc_enabled,
    // core handshake
    input wire logic halt_exec,
    input wire logic irq_zero_taken,
    // external pin
    input wire logic ext_irq_zero_pin,
    // wake sources
    input wire swk_wake_t wake_src,
    // outputs
    output swk_gate_t gate,
    output logic irq_zero_req,
    output logic adc_start,
    output logic core_stall,
    output logic wake_pulse,
    output logic asleep,
    output logic [2:0] active_mode,
    output logic mode_reserved
);
    // two-stage pin synchroniser plus history for edge detect
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic irq_flag;
    logic next_irq_flag;
    logic cond_hit;
    logic [1:0] sense;

    // pin sampled on the clock before any logic looks at it
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
            pin_prev <= 1'b1;
        end
        else
        begin
            pin_meta <= ext_irq_zero_pin; // [RULE2]
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // sense condition on the sampled pin
    always_comb
    begin
        sense = {irq_zero_sense_hi, irq_zero_sense_lo};
        unique case (sense) // [RULE5]
            SWK_SENSE_LOW: cond_hit = !pin_sync;
            SWK_SENSE_ANY: cond_hit = pin_sync != pin_prev; // [RULE3]
            SWK_SENSE_FALL: cond_hit = pin_prev && !pin_sync;
            SWK_SENSE_RISE: cond_hit = !pin_prev && pin_sync;
        endcase
    end

    // edge flag is sticky until the core takes it; level mode follows the pin
    always_comb
    begin
        if (sense == SWK_SENSE_LOW)
            next_irq_flag = cond_hit; // level: source must hold it [RULE4]
        else if (cond_hit)
            next_irq_flag = 1'b1; // set wins over the take [RULE3]
        else if (irq_zero_taken)
            next_irq_flag = 1'b0;
        else
            next_irq_flag = irq_flag;
    end

    logic next_irq_req;
    assign next_irq_req = next_irq_flag && global_irq_en && irq_zero_mask; // [RULE1]

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            irq_flag <= 1'b0;
            irq_zero_req <= 1'b0;
        end
        else
        begin
            irq_flag <= next_irq_flag;
            irq_zero_req <= next_irq_req;
        end
    end

    // sleep state machine
    swk_state_t state;
    swk_state_t next_state;
    logic [2:0] stall_cnt;
    logic [2:0] next_stall_cnt;
    logic [2:0] mode;
    logic [2:0] next_mode;
    logic wake_hit;
    logic enter;
    logic irq0_wake;

    // irq 0 wakes only when enabled; only its low level may wake adc noise mode
    assign irq0_wake = next_irq_req;
    assign enter = halt_exec && sleep_allow; // [RULE6]

    // wake qualification per mode
    always_comb
    begin
        unique case (mode)
            SWK_MODE_IDLE: // [RULE12] [RULE13]
                wake_hit = irq0_wake || wake_src.ext_irq || wake_src.int_irq
                    || (wake_src.comparator && !comparator_off);
            SWK_MODE_ADC_NR: // [RULE16] [RULE17]
                wake_hit = wake_src.adc_done || wake_src.twi_match
                    || wake_src.ext_level || wake_src.ext_edge2
                    || (irq0_wake && sense == SWK_SENSE_LOW)
                    || wake_src.t2_event;
            SWK_MODE_PDOWN, SWK_MODE_STBY:
                wake_hit = wake_src.twi_match || wake_src.ext_level
                    || wake_src.ext_edge2 || (irq0_wake && sense == SWK_SENSE_LOW);
            SWK_MODE_PSAVE, SWK_MODE_XSTBY:
                wake_hit = wake_src.twi_match || wake_src.ext_level
                    || wake_src.ext_edge2 || (irq0_wake && sense == SWK_SENSE_LOW)
                    || (wake_src.t2_event && wake_src.t2_async);
            SWK_MODE_RSV4, SWK_MODE_RSV5:
                wake_hit = irq0_wake || wake_src.ext_irq || wake_src.int_irq;
        endcase
    end

    // sequencing: run -> sleep -> four-cycle stall -> run; reset restarts
    always_comb
    begin
        next_state = state;
        next_stall_cnt = stall_cnt;
        next_mode = mode;
        unique case (state)
            SWK_RUN:
                if (enter)
                begin
                    next_state = SWK_SLEEP;
                    next_mode = sleep_sel_field; // [RULE7]
                end
            SWK_SLEEP:
                if (wake_hit)
                begin
                    next_state = SWK_STALL; // [RULE8]
                    next_stall_cnt = SWK_STALL_RST;
                end
            SWK_STALL:
                if (stall_cnt == SWK_STALL_LAST)
                    next_state = SWK_RUN;
                else
                    next_stall_cnt = stall_cnt + 3'h1;
            default:
                next_state = SWK_RUN;
        endcase
    end

    // clock gates derived from state and mode
    swk_gate_t next_gate;
    always_comb
    begin
        next_gate = '1;
        if (next_state != SWK_RUN)
        begin
            next_gate.cpu = 1'b0;
        end
        if (next_state == SWK_SLEEP)
        begin
            unique case (next_mode) // [RULE18]
                SWK_MODE_IDLE:
                    next_gate.comparator = !comparator_off; // [RULE11] [RULE13]
                SWK_MODE_ADC_NR:
                begin
                    next_gate.spi = 1'b0; // [RULE15]
                    next_gate.usart = 1'b0;
                    next_gate.comparator = 1'b0;
                    next_gate.timers = 1'b0;
                end
                default:
                begin
                    next_gate.spi = 1'b0;
                    next_gate.usart = 1'b0;
                    next_gate.comparator = 1'b0;
                    next_gate.adc = 1'b0;
                    next_gate.timers = 1'b0;
                    next_gate.timer2 = next_mode[0];
                end
            endcase
        end
        else if (comparator_off)
            next_gate.comparator = 1'b0;
    end

    logic next_adc_start;
    assign next_adc_start = state == SWK_RUN && enter && adc_enabled
        && (sleep_sel_field == SWK_MODE_IDLE || sleep_sel_field == SWK_MODE_ADC_NR); // [RULE14]

    // register the state; rst also covers reset-while-asleep [RULE10]
    // only sequencing state is touched, memory contents are not ours [RULE9]
    // sleep_allow is an input, never cleared here [RULE19]
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state <= SWK_RUN;
            stall_cnt <= SWK_STALL_RST;
            mode <= SWK_MODE_IDLE;
            gate <= '1;
            adc_start <= 1'b0;
            core_stall <= 1'b0;
            wake_pulse <= 1'b0;
            asleep <= 1'b0;
            active_mode <= SWK_MODE_IDLE;
            mode_reserved <= 1'b0;
        end
        else
        begin
            state <= next_state;
            stall_cnt <= next_stall_cnt;
            mode <= next_mode;
            gate <= next_gate;
            adc_start <= next_adc_start;
            core_stall <= next_state == SWK_STALL;
            wake_pulse <= state == SWK_SLEEP && next_state == SWK_STALL;
            asleep <= next_state == SWK_SLEEP;
            active_mode <= next_mode;
            mode_reserved <= next_mode == SWK_MODE_RSV4 || next_mode == SWK_MODE_RSV5;
        end
    end

    // checks
    no_irq_masked_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
        irq_zero_req |-> $past(global_irq_en) && $past(irq_zero_mask))
        else $error("irq 0 raised while masked");
    fall_latch_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE5]
        sense == SWK_SENSE_FALL && pin_prev && !pin_sync && global_irq_en && irq_zero_mask
        |=> irq_zero_req)
        else $error("falling edge missed");
    no_sleep_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE6]
        state == SWK_RUN && halt_exec && !sleep_allow |=> !asleep)
        else $error("slept without sleep_allow");
    enter_sleep_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE7]
        state == SWK_RUN && enter |=> asleep && active_mode == $past(sleep_sel_field))
        else $error("sleep entry wrong");
    stall_four_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE8]
        wake_pulse |-> core_stall [*4] ##1 !core_stall)
        else $error("stall not four cycles");
    cmp_off_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE13]
        comparator_off |=> !gate.comparator)
        else $error("comparator not powered down");
    adc_auto_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE14]
        state == SWK_RUN && enter && adc_enabled && sleep_sel_field == SWK_MODE_IDLE
        |=> adc_start)
        else $error("adc conversion not started");
    adcnr_gate_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE15]
        asleep && active_mode == SWK_MODE_ADC_NR |-> gate.adc && gate.timer2
        && !gate.cpu && !gate.spi)
        else $error("adc noise gating wrong");
    adcnr_t2_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE17]
        state == SWK_SLEEP && mode == SWK_MODE_ADC_NR && wake_src.t2_event |=> wake_pulse)
        else $error("timer 2 did not wake");
    idle_gate_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE11]
        asleep && active_mode == SWK_MODE_IDLE |-> !gate.cpu && gate.spi && gate.usart
        && gate.adc && gate.twi && gate.timers && gate.timer2 && gate.watchdog)
        else $error("idle gating wrong");
    idle_wake_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE12]
        state == SWK_SLEEP && mode == SWK_MODE_IDLE && (wake_src.int_irq || wake_src.ext_irq)
        |=> wake_pulse && core_stall)
        else $error("idle did not wake");
endmodule : swk_sleep_ctrl

// ===== tb/swk_pin_src.sv
// model of the source that drives the external irq 0 pin
`timescale 1ns/1ps
module swk_pin_src (
    // clock
    input wire logic ref_clk,
    // pin, idles high as with a pull-up
    output logic ext_irq_zero_pin
);
    initial ext_irq_zero_pin = 1'b1;

    // hold a level until told otherwise, as low sense needs
    task automatic drive(input logic lvl);
        @(posedge ref_clk);
        #1 ext_irq_zero_pin = lvl;
    endtask : drive

    // pulses held for n clocks; n of 2 or more keeps them wider than one clock
    task automatic pulse(input logic lvl, input int n);
        drive(lvl);
        repeat (n) @(posedge ref_clk);
        #1 ext_irq_zero_pin = ~lvl;
    endtask : pulse
endmodule : swk_pin_src

// ===== tb/swk_sleep_ctrl_tb.sv
// self-checking testbench for the sleep/wake and irq 0 block
`timescale 1ns/1ps
module swk_sleep_ctrl_tb
    import swk_pkg::*;
;
    logic ref_clk, rst, sleep_allow, hi, lo, gie, msk, cmp_off, adc_en, halt, taken;
    logic [2:0] sel;
    swk_wake_t wk;
    wire logic pin;
    swk_gate_t gate;
    logic req, adc_start, stall, wpulse, asleep, rsv;
    logic [2:0] mode;
    int fails, tests_run;

    swk_pin_src swk_pin_src_inst (.ref_clk(ref_clk), .ext_irq_zero_pin(pin));

    swk_sleep_ctrl swk_sleep_ctrl_inst (
        .ref_clk(ref_clk), .rst(rst), .sleep_allow(sleep_allow),
        .sleep_sel_field(sel), .irq_zero_sense_hi(hi), .irq_zero_sense_lo(lo),
        .global_irq_en(gie), .irq_zero_mask(msk), .comparator_off(cmp_off),
        .adc_enabled(adc_en), .halt_exec(halt), .irq_zero_taken(taken),
        .ext_irq_zero_pin(pin), .wake_src(wk), .gate(gate), .irq_zero_req(req),
        .adc_start(adc_start), .core_stall(stall), .wake_pulse(wpulse),
        .asleep(asleep), .active_mode(mode), .mode_reserved(rsv)
    );

    // free-running clock, 40 ns period
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // drives land 1 ns after the edge so no race with the design
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic results();
        if (fails == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    task automatic take_irq();
        taken = 1'b1;
        tick(1);
        taken = 1'b0;
        tick(1);
    endtask : take_irq

    task automatic sleep_in(input logic [2:0] m);
        sel = m;
        halt = 1'b1;
        tick(1);
        halt = 1'b0;
    endtask : sleep_in

    task automatic wake_by(input logic [8:0] bits);
        wk = swk_wake_t'(bits);
        tick(1);
        wk = '0;
    endtask : wake_by

    // each sense code against a falling then a rising pin edge
    task automatic t_sense();
        logic [3:0] efall, erise;
        efall = 4'h7;
        erise = 4'ha;
        for (int s = 0; s < 4; s++)
        begin
            {hi, lo} = 2'(s);
            swk_pin_src_inst.drive(1'b0);
            tick(1);
            chk("req_raw_pin", req, 0);
            tick(4);
            chk("req_fall", req, efall[s]);
            take_irq();
            swk_pin_src_inst.drive(1'b1);
            tick(5);
            chk("req_rise", req, erise[s]);
            take_irq();
            chk("req_clear", req, 0);
        end
    endtask : t_sense

    // masked edge latches but only shows once both enables are set
    task automatic t_mask();
        {hi, lo} = SWK_SENSE_FALL;
        gie = 1'b0;
        swk_pin_src_inst.pulse(1'b0, 2);
        tick(5);
        chk("req_gie_off", req, 0);
        gie = 1'b1;
        tick(2);
        chk("req_short_pulse", req, 1);
        msk = 1'b0;
        tick(2);
        chk("req_mask_off", req, 0);
        msk = 1'b1;
        take_irq();
        chk("req_taken", req, 0);
    endtask : t_mask

    // refused halt, then every mode code left again by reset
    task automatic t_halt();
        sleep_allow = 1'b0;
        sleep_in(SWK_MODE_IDLE);
        chk("asleep_no_allow", asleep, 0);
        sleep_allow = 1'b1;
        for (int m = 0; m < 8; m++)
        begin
            sleep_in(3'(m));
            chk("asleep", asleep, 1);
            chk("mode", mode, m);
            chk("reserved", rsv, m == 4 || m == 5);
            chk("adc_start_off", adc_start, 0);
            chk("cpu_gate", gate.cpu, 0);
            rst = 1'b1;
            tick(1);
            rst = 1'b0;
            chk("asleep_rst", asleep, 0);
            chk("gate_rst", 16'(gate), 16'h03ff);
        end
    endtask : t_halt

    // idle with comparator off, then the four-cycle stall on wake
    task automatic t_idle();
        adc_en = 1'b1;
        cmp_off = 1'b1;
        sleep_in(SWK_MODE_IDLE);
        chk("adc_start_idle", adc_start, 1);
        chk("gate_idle", 16'(gate), 16'h01bf);
        wake_by(9'h010);
        chk("asleep_cmp_off", asleep, 1);
        tick(1);
        wake_by(9'h020);
        chk("wake_pulse", wpulse, 1);
        chk("asleep_woke", asleep, 0);
        chk("stall_1", stall, 1);
        for (int i = 2; i < 5; i++)
        begin
            tick(1);
            chk("stall_n", stall, 1);
        end
        tick(1);
        chk("stall_end", stall, 0);
        chk("cpu_resume", gate.cpu, 1);
        cmp_off = 1'b0;
        // comparator powered again: its irq wakes idle, as does an external one
        sleep_in(SWK_MODE_IDLE);
        chk("gate_idle_cmp", 16'(gate), 16'h01ff);
        wake_by(9'h010);
        chk("wake_cmp", wpulse, 1);
        tick(5);
        sleep_in(SWK_MODE_IDLE);
        wake_by(9'h100);
        chk("wake_ext", wpulse, 1);
        tick(5);
        // falling pin edge reaches the core through the synchroniser and wakes it
        sleep_in(SWK_MODE_IDLE);
        swk_pin_src_inst.drive(1'b0);
        tick(3);
        chk("wake_irq0", wpulse, 1);
        chk("req_irq0", req, 1);
        take_irq();
        swk_pin_src_inst.drive(1'b1);
        tick(4);
    endtask : t_idle

    // noise mode: internal irq ignored, each listed source wakes
    task automatic t_adcnr();
        logic [8:0] src [5];
        src = '{9'h080, 9'h040, 9'h008, 9'h004, 9'h002};
        for (int i = 0; i < 5; i++)
        begin
            sleep_in(SWK_MODE_ADC_NR);
            chk("adc_start_nr", adc_start, 1);
            chk("gate_adc", {gate.adc, gate.spi, gate.watchdog}, 3'h5);
            wake_by(9'h020);
            chk("asleep_int_irq", asleep, 1);
            tick(1);
            wake_by(src[i]);
            chk("wake_nr", wpulse, 1);
            tick(6);
        end
    endtask : t_adcnr

    // main sequence
    initial
    begin
        fails = 0;
        tests_run = 0;
        {rst, sleep_allow, hi, lo, gie, msk} = 6'h31;
        {cmp_off, adc_en, halt, taken, sel} = '0;
        gie = 1'b1;
        wk = '0;
        tick(2);
        rst = 1'b0;
        chk("gate_reset", 16'(gate), 16'h03ff);
        chk("outs_reset", {req, stall, wpulse, asleep, mode}, 0);
        t_sense();
        t_mask();
        t_halt();
        t_idle();
        t_adcnr();
        results();
    end
endmodule : swk_sleep_ctrl_tb
